// *** pkg/sysbus_consts.svh ***
// constants for the system bus pin interface
`ifndef SYSBUS_CONSTS_SVH
`define SYSBUS_CONSTS_SVH

`define SYS_AD_W 32
`define SYS_CMD_W 9
`define SYS_CMD_NARROW_W 5
`define SYS_KINDS 3
`define STRAP_WIDE 1'h1
`define PIN_OFF_N 1'h1
`define PIN_ON_N 1'h0
`define AD_RESET 32'h0000_0000
`define CMD_RESET 9'h000
`define UPPER_CMD_ZERO 4'h0

`endif

// *** pkg/sysbus_pkg.sv ***
// types shared by the system bus pin interface
package sysbus_pkg;
  `include "sysbus_consts.svh"

  // what a processor word opens on the bus
  typedef enum logic [1:0] {
    KIND_READ,
    KIND_WRITE,
    KIND_DATA
  } tx_kind_t;

  // one address/data word with its command or identifier
  typedef struct packed {
    logic [`SYS_AD_W-1:0] ad;
    logic [`SYS_CMD_W-1:0] cmd;
  } sys_word_t;

  // who may drive the shared bus
  typedef enum logic [1:0] {
    OWN_BUS,
    HANDING_OFF,
    AGENT_BUS
  } owner_state_t;
endpackage

// *** logic/bus_owner_ctl.sv ***
// bus ownership tracker with release and master pin
`timescale 1ns/1ps
`include "sysbus_consts.svh"

module bus_owner_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic wide_mode,
  input wire logic agent_req,
  output logic own_r,
  output logic handoff_pin_n_r
);
  sysbus_pkg::owner_state_t state_r;
  sysbus_pkg::owner_state_t state_nxt;
  logic own_nxt;
  logic handoff_pin_n_nxt;

  // the processor owns the bus after reset; one handing-off cycle lets
  // our drivers turn off before the agent may drive
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sysbus_pkg::OWN_BUS: begin
        if (agent_req) begin
          state_nxt = sysbus_pkg::HANDING_OFF;
        end
      end
      sysbus_pkg::HANDING_OFF: begin
        state_nxt = sysbus_pkg::AGENT_BUS;
      end
      sysbus_pkg::AGENT_BUS: begin
        if (!agent_req) begin
          state_nxt = sysbus_pkg::OWN_BUS; // agent stops driving with req
        end
      end
    endcase
  end

  // pin 31 carries release in wide mode, ownership in narrow mode
  always_comb begin
    own_nxt = (state_nxt == sysbus_pkg::OWN_BUS);
    if (wide_mode) begin
      handoff_pin_n_nxt = ~(state_nxt == sysbus_pkg::HANDING_OFF);
    end else begin
      handoff_pin_n_nxt = ~own_nxt;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sysbus_pkg::OWN_BUS;
      own_r <= 1'b1;
      // narrow mode shows ownership from reset on, as we own the bus
      handoff_pin_n_r <= wide_mode ? `PIN_OFF_N : `PIN_ON_N;
    end else begin
      state_r <= state_nxt;
      own_r <= own_nxt;
      handoff_pin_n_r <= handoff_pin_n_nxt;
    end
  end
endmodule

// *** logic/sysbus_port.sv ***
// processor side of the shared system address/data and command bus
`timescale 1ns/1ps
`include "sysbus_consts.svh"

module sysbus_port #(
  parameter int AD_W = `SYS_AD_W,
  parameter int CMD_W = `SYS_CMD_W,
  parameter int NARROW_W = `SYS_CMD_NARROW_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic compat_select,
  input wire logic agent_valid_n,
  input wire logic agent_bus_request_n,
  input wire logic agent_write_ok_n,
  input wire logic agent_read_ok_n,
  input wire logic [AD_W-1:0] sad_in,
  output logic [AD_W-1:0] sad_out,
  output logic [AD_W-1:0] sad_oe_n,
  input wire logic [CMD_W-1:0] cmd_in,
  output logic [CMD_W-1:0] cmd_out,
  output logic [CMD_W-1:0] cmd_oe_n,
  output logic proc_valid_n,
  output logic proc_release_n,
  input wire logic tx_valid,
  input wire sysbus_pkg::tx_kind_t tx_kind,
  input wire sysbus_pkg::sys_word_t tx_word,
  output logic [`SYS_KINDS-1:0] tx_ready,
  output logic rx_valid,
  output sysbus_pkg::sys_word_t rx_word,
  output logic wide_mode
);
  // the word struct is fixed; other widths cannot be carried
  if (AD_W != `SYS_AD_W || CMD_W != `SYS_CMD_W ||
      NARROW_W >= CMD_W || NARROW_W < 1) begin : g_bad_widths
    $error("sysbus_port: unsupported bus widths");
  end

  logic own_r;
  logic agent_req;
  logic taken;
  logic kind_ok;
  logic wide_mode_r;
  logic mode_now;
  logic [CMD_W-1:0] cmd_oe_rst;
  logic [AD_W-1:0] sad_out_r;
  logic [AD_W-1:0] sad_out_nxt;
  logic [AD_W-1:0] sad_oe_n_r;
  logic [AD_W-1:0] sad_oe_n_nxt;
  logic [CMD_W-1:0] cmd_out_r;
  logic [CMD_W-1:0] cmd_out_nxt;
  logic [CMD_W-1:0] cmd_oe_n_r;
  logic [CMD_W-1:0] cmd_oe_n_nxt;
  logic proc_valid_n_r;
  logic proc_valid_n_nxt;
  logic [`SYS_KINDS-1:0] tx_ready_r;
  logic [`SYS_KINDS-1:0] tx_ready_nxt;
  logic rx_valid_r;
  logic rx_valid_nxt;
  sysbus_pkg::sys_word_t rx_word_r;
  sysbus_pkg::sys_word_t rx_word_nxt;

  // all control pins are active low; the bus request is converted once at the edge
  assign agent_req = ~agent_bus_request_n;

  // strap is caught every reset cycle and frozen at release
  always_ff @(posedge clk) begin
    if (rst) begin
      wide_mode_r <= (compat_select == `STRAP_WIDE);
    end else begin
      wide_mode_r <= wide_mode_r;
    end
  end

  // during reset the strap itself sets the pin levels, so the first
  // cycle after release already shows the right mode
  assign mode_now = rst ? (compat_select == `STRAP_WIDE) : wide_mode_r;

  bus_owner_ctl owner_u (
    .clk(clk),
    .rst(rst),
    .wide_mode(mode_now),
    .agent_req(agent_req),
    .own_r(own_r),
    .handoff_pin_n_r(proc_release_n)
  );

  // a kind is offered only while we own the bus with no request pending
  // and, for writes and wide-mode reads, the agent has said it can take it; ready lags the agent by a cycle
  always_comb begin
    tx_ready_nxt = '0;
    if (own_r && !agent_req) begin
      tx_ready_nxt[sysbus_pkg::KIND_DATA] = 1'b1;
      tx_ready_nxt[sysbus_pkg::KIND_WRITE] = ~agent_write_ok_n;
      // narrow mode read-ready is reserved, so reads are not gated there
      tx_ready_nxt[sysbus_pkg::KIND_READ] =
        wide_mode_r ? ~agent_read_ok_n : 1'b1;
    end
  end

  assign kind_ok = tx_ready_r[tx_kind];
  assign taken = tx_valid && kind_ok;

  // one word per taken request, valid for exactly one cycle
  always_comb begin
    sad_out_nxt = sad_out_r;
    cmd_out_nxt = cmd_out_r;
    proc_valid_n_nxt = `PIN_OFF_N;
    if (taken) begin
      sad_out_nxt = tx_word.ad;
      cmd_out_nxt = tx_word.cmd;
      proc_valid_n_nxt = `PIN_ON_N;
    end
    if (!wide_mode_r) begin
      cmd_out_nxt[CMD_W-1:NARROW_W] = '0;
    end
  end

  // drivers follow ownership; the upper command pins in narrow mode go
  // to no one, so they always drive zero
  always_comb begin
    sad_oe_n_nxt = {AD_W{~own_r}};
    cmd_oe_n_nxt = {CMD_W{~own_r}};
    cmd_oe_rst = '1;
    if (!wide_mode_r) begin
      cmd_oe_n_nxt[CMD_W-1:NARROW_W] = '0;
    end
    // reset already holds the unused pins low, or they float a cycle
    if (!mode_now) begin
      cmd_oe_rst[CMD_W-1:NARROW_W] = '0;
    end
  end

  // capture agent words only while the agent owns the bus
  always_comb begin
    rx_valid_nxt = 1'b0;
    rx_word_nxt = rx_word_r;
    if (!own_r && !agent_valid_n) begin
      rx_valid_nxt = 1'b1;
      rx_word_nxt.ad = sad_in;
      rx_word_nxt.cmd = cmd_in;
      if (!wide_mode_r) begin
        rx_word_nxt.cmd[CMD_W-1:NARROW_W] = '0;
      end
    end
  end

  // pin and user-side registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sad_out_r <= `AD_RESET;
      sad_oe_n_r <= '1;
      cmd_out_r <= `CMD_RESET;
      cmd_oe_n_r <= cmd_oe_rst;
      proc_valid_n_r <= `PIN_OFF_N;
      tx_ready_r <= '0;
      rx_valid_r <= 1'b0;
      rx_word_r <= '0;
    end else begin
      sad_out_r <= sad_out_nxt;
      sad_oe_n_r <= sad_oe_n_nxt;
      cmd_out_r <= cmd_out_nxt;
      cmd_oe_n_r <= cmd_oe_n_nxt;
      proc_valid_n_r <= proc_valid_n_nxt;
      tx_ready_r <= tx_ready_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_word_r <= rx_word_nxt;
    end
  end

  assign sad_out = sad_out_r;
  assign sad_oe_n = sad_oe_n_r;
  assign cmd_out = cmd_out_r;
  assign cmd_oe_n = cmd_oe_n_r;
  assign proc_valid_n = proc_valid_n_r;
  assign tx_ready = tx_ready_r;
  assign rx_valid = rx_valid_r;
  assign rx_word = rx_word_r;
  assign wide_mode = wide_mode_r;

  // checks on the pins this block drives
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence req_while_owned_s;
    own_r && agent_req && wide_mode_r;
  endsequence

  sequence release_pulse_s;
    !proc_release_n ##1 proc_release_n;
  endsequence

  idle_after_reset_a: assert property (
    $fell(rst) |-> proc_valid_n && proc_release_n == wide_mode_r &&
                   tx_ready == '0 && !rx_valid)
    else $error("control pins not idle after reset");

  strap_frozen_a: assert property (
    $past(!rst) |-> $stable(wide_mode_r))
    else $error("mode changed outside reset");

  narrow_upper_zero_a: assert property (
    !wide_mode_r |-> cmd_out[CMD_W-1:NARROW_W] == '0 &&
                     cmd_oe_n[CMD_W-1:NARROW_W] == '0)
    else $error("narrow mode upper command pins not driven zero");

  narrow_rx_cmd_a: assert property (
    rx_valid && !wide_mode_r |-> rx_word.cmd[CMD_W-1:NARROW_W] == '0)
    else $error("narrow mode upper command bits captured");

  take_to_valid_a: assert property (
    taken |=> !proc_valid_n && sad_out == $past(tx_word.ad) &&
              !sad_oe_n[0] && !cmd_oe_n[0])
    else $error("taken word not driven with valid");

  valid_only_take_a: assert property (
    !taken |=> proc_valid_n)
    else $error("valid driven without a taken word");

  write_ready_gate_a: assert property (
    taken && tx_kind == sysbus_pkg::KIND_WRITE |->
      $past(!agent_write_ok_n))
    else $error("write taken without write ready");

  owner_drives_a: assert property (
    !sad_oe_n[0] |-> $past(own_r) && sad_oe_n == '0 &&
                     cmd_oe_n[NARROW_W-1:0] == '0)
    else $error("address bus driven while not owner");

  release_handoff_a: assert property (
    req_while_owned_s |=> release_pulse_s ##0 !own_r)
    else $error("release not pulsed on handoff");

  owner_pin_a: assert property (
    !wide_mode_r |-> proc_release_n == !own_r)
    else $error("master pin does not follow ownership");
endmodule

// *** tb/sysbus_agent.sv ***
// behavioural external agent on the far side of the system bus
`timescale 1ns/1ps
module sysbus_agent (
  input wire logic clk,
  input wire logic compat_select,
  input wire logic take,
  input wire logic wr_ok,
  input wire logic rd_ok,
  input wire logic send,
  input wire sysbus_pkg::sys_word_t sw,
  input wire logic [31:0] sad_out,
  input wire logic [31:0] sad_oe_n,
  input wire logic [8:0] cmd_out,
  input wire logic [8:0] cmd_oe_n,
  output logic [31:0] sad_in,
  output logic [8:0] cmd_in,
  output logic agent_valid_n,
  output logic agent_bus_request_n,
  output logic agent_write_ok_n,
  output logic agent_read_ok_n,
  output logic drv
);
  sysbus_pkg::sys_word_t last_r;
  // drive only once every processor address driver is off
  assign drv = take & (&sad_oe_n);
  assign agent_bus_request_n = ~take;
  assign agent_valid_n = ~(send & drv);
  assign agent_write_ok_n = ~wr_ok;
  // reserved input rests on its pull-down in narrow mode
  assign agent_read_ok_n = compat_select & ~rd_ok;
  // released lines flip each cycle so stale data never looks valid
  assign sad_in = ~sad_oe_n & sad_out
    | sad_oe_n & (drv ? sw.ad : ~last_r.ad);
  assign cmd_in = ~cmd_oe_n & cmd_out
    | cmd_oe_n & (drv ? sw.cmd : ~last_r.cmd);
  always_ff @(posedge clk) last_r <= {sad_in, cmd_in};
endmodule

// *** tb/tb.sv ***
// self-checking bench for the system bus port
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, compat_select = 1, take = 0, send = 0;
  logic wr_ok = 1, rd_ok = 1, tx_valid = 0, drv, rx_valid, wide_mode;
  logic agent_valid_n, agent_bus_request_n, agent_write_ok_n;
  logic agent_read_ok_n, proc_valid_n, proc_release_n;
  logic [31:0] sad_in, sad_out, sad_oe_n, seed = 32'h0001_2e95;
  logic [8:0] cmd_in, cmd_out, cmd_oe_n;
  logic [2:0] tx_ready;
  sysbus_pkg::tx_kind_t tx_kind = sysbus_pkg::KIND_READ;
  sysbus_pkg::sys_word_t tx_word = '0, sw = '0, rx_word, txq[$], rxq[$];
  int error_cnt = 0, check_count = 0, rel_cnt = 0;
  sysbus_port i_sysbus_port (.clk, .rst, .compat_select, .agent_valid_n,
    .agent_bus_request_n, .agent_write_ok_n, .agent_read_ok_n, .sad_in,
    .sad_out, .sad_oe_n, .cmd_in, .cmd_out, .cmd_oe_n, .proc_valid_n,
    .proc_release_n, .tx_valid, .tx_kind, .tx_word, .tx_ready, .rx_valid,
    .rx_word, .wide_mode);
  sysbus_agent i_sysbus_agent (.clk, .compat_select, .take, .wr_ok, .rd_ok,
    .send, .sw, .sad_out, .sad_oe_n, .cmd_out, .cmd_oe_n, .sad_in, .cmd_in,
    .agent_valid_n, .agent_bus_request_n, .agent_write_ok_n,
    .agent_read_ok_n, .drv);
  task automatic check(input logic [40:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic sysbus_pkg::sys_word_t wrd();
    wrd.ad = rnd();
    wrd.cmd = 9'(rnd());
  endfunction
  // narrow mode carries only the low command bits
  function automatic sysbus_pkg::sys_word_t fit(sysbus_pkg::sys_word_t w);
    if (!compat_select) w.cmd[8:5] = 4'h0;
    return w;
  endfunction
  task automatic boot(input logic m);
    compat_select = m;
    rst = 1;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    @(posedge clk) #1;
  endtask
  // the user request stays up so words can follow back to back
  task automatic put(input int k, input sysbus_pkg::sys_word_t w);
    tx_valid = 1;
    tx_kind = sysbus_pkg::tx_kind_t'(k);
    tx_word = w;
    for (int n = 0; n < 40 && tx_ready[k] !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk) txq.push_back(fit(w));
    #1;
  endtask
  task automatic hand(input logic m);
    take = 1;
    rel_cnt = 0;
    for (int n = 0; n < 20 && drv !== 1'b1; n++) @(posedge clk) #1;
    if (m) check(rel_cnt, 1, "release");
    check(proc_release_n, 1, "master");
    check(tx_ready, 0, "ready");
    for (int i = 0; i < 4; i++) begin
      sw = wrd();
      send = 1;
      @(posedge clk) rxq.push_back(fit(sw));
      #1;
    end
    send = 0;
    take = 0;
    repeat (3) @(posedge clk);
    #1 check(proc_release_n, m, "back");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // every word on the pins retires the oldest note; looked at on the
  // falling edge so the launching edge cannot race the compare
  always @(negedge clk) begin
    if (proc_release_n === 1'b0) rel_cnt++;
    if (proc_valid_n === 1'b0) begin
      check(sad_oe_n, 0, "tx oe");
      check({sad_out, cmd_out}, txq.size() ? txq.pop_front() : 'x,
        "tx word");
    end
    if (rx_valid === 1'b1)
      check(rx_word, rxq.size() ? rxq.pop_front() : 'x, "rx");
  end
  initial forever #2.5 clk = ~clk;
  // guards against a stalled handshake
  initial begin
    #10000 error_cnt++;
    stop_test();
  end
  initial begin
    for (int m = 1; m >= 0; m--) begin
      boot(m[0]);
      check(wide_mode, m, "mode");
      check(proc_release_n, m, "reset pin");
      for (int i = 0; i < 9; i++) put(i % 3, wrd());
      tx_valid = 0;
      check(proc_release_n, m, "own");
      wr_ok = 0;
      rd_ok = 0;
      // ready lags the agent by one edge, so let it settle first
      @(posedge clk) #1;
      tx_kind = sysbus_pkg::KIND_WRITE;
      tx_valid = 1;
      repeat (4) @(posedge clk);
      #1 check(tx_ready[1], 0, "wr held");
      check(tx_ready[0], !m, "rd held");
      wr_ok = 1;
      rd_ok = 1;
      put(1, wrd());
      tx_valid = 0;
      hand(m[0]);
      put(2, wrd());
      tx_valid = 0;
      repeat (4) @(posedge clk) #1;
    end
    check(txq.size() + rxq.size(), 0, "left");
    stop_test();
  end
endmodule
